/* File: sgm_pkg.sv */
// Constants, register map and carrier types for the servo gain and mode switch block.
// Assumes a Wishbone classic slave with 32-bit data and one aligned word per register.
package sgm_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [5:0] REG_CUR_GAIN = 6'h00;
  localparam logic [5:0] REG_APP_SEL = 6'h04;
  localparam logic [5:0] REG_FF_GAIN = 6'h08;
  localparam logic [5:0] REG_FF_TIME = 6'h0c;
  localparam logic [5:0] REG_SW_COND = 6'h10;
  localparam logic [5:0] REG_TRQ_THR = 6'h14;
  localparam logic [5:0] REG_SPD_THR = 6'h18;
  localparam logic [5:0] REG_ACC_THR = 6'h1c;
  localparam logic [5:0] REG_PERR_THR = 6'h20;
  localparam logic [5:0] REG_NOTCH_EN = 6'h24;
  localparam logic [5:0] REG_SPD_GAIN = 6'h28;
  localparam logic [5:0] REG_STATUS = 6'h2c;
  // ---------------------------------------------------------------
  // Reset values, limits and fields
  // ---------------------------------------------------------------
  localparam logic [15:0] CUR_GAIN_RST = 16'h07d0;
  localparam logic [15:0] CUR_GAIN_MIN = 16'h0064;
  localparam logic [15:0] CUR_GAIN_MAX = 16'h07d0;
  localparam logic [15:0] FF_GAIN_MAX = 16'h0064;
  localparam logic [15:0] FF_TIME_MAX = 16'h1900;
  localparam logic [15:0] TRQ_THR_RST = 16'h00c8;
  localparam logic [15:0] TRQ_THR_MAX = 16'h0320;
  localparam logic [15:0] SPD_THR_MAX = 16'h2710;
  localparam logic [15:0] ACC_THR_MAX = 16'h7530;
  localparam logic [15:0] ACC_THR_RST = 16'h0000;
  localparam logic [15:0] SPD_GAIN_RST = 16'h0028;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [15:0] PCT_DIV = 16'h0064;
  localparam int SPD_DET_BIT = 8;
  localparam int NOTCH1_BIT = 0;
  localparam int NOTCH2_BIT = 8;
  localparam int COND_LSB = 0;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int LOOP_US = 1;
  localparam int LOOP_CYC = CLK_MHZ * LOOP_US;
  localparam int FF_STEP_NS = 10000;
  localparam int LOOP_NS = LOOP_US * 1000;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    COND_TORQUE = 5'h01,
    COND_SPEED = 5'h02,
    COND_ACCEL = 5'h04,
    COND_PERR = 5'h08,
    COND_OFF = 5'h10
  } sgm_cond_type;
  typedef struct packed {
    logic [15:0] trq_thr;
    logic [15:0] spd_thr;
    logic [15:0] acc_thr;
    logic [15:0] perr_thr;
    logic [3:0] cond;
  } sgm_switch_cfg_type;
  typedef struct packed {
    logic signed [15:0] torque;
    logic signed [15:0] speed;
    logic signed [15:0] accel;
    logic signed [15:0] perr;
  } sgm_levels_type;
endpackage

/* File: sgm_mode_switch.sv */
// P/PI mode switch decision, evaluated on each speed loop tick.
// Assumes levels are signed, sampled in the same clock domain.
`timescale 1ns/1ps
module sgm_mode_switch
  import sgm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Inputs
  input wire logic tick,
  input wire logic pos_mode,
  input wire sgm_switch_cfg_type cfg,
  input wire sgm_levels_type lev,
  // Result
  output logic p_mode
);
  sgm_cond_type state_q;
  logic p_d;
  logic p_q;
  function automatic logic [15:0] mag(input logic signed [15:0] v);
    mag = v[15] ? 16'(-v) : 16'(v);
  endfunction
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= COND_TORQUE;
    end else begin
      case (cfg.cond)
        4'h0: state_q <= COND_TORQUE;
        4'h1: state_q <= COND_SPEED;
        4'h2: state_q <= COND_ACCEL;
        4'h3: state_q <= COND_PERR;
        default: state_q <= COND_OFF;
      endcase
    end
  end
  always_comb begin
    case (state_q)
      COND_TORQUE: p_d = mag(lev.torque) > cfg.trq_thr;
      COND_SPEED: p_d = mag(lev.speed) > cfg.spd_thr;
      COND_ACCEL: p_d = mag(lev.accel) > cfg.acc_thr;
      COND_PERR: p_d = pos_mode && (mag(lev.perr) > cfg.perr_thr);
      COND_OFF: p_d = 1'b0;
      default: p_d = 1'b0;
    endcase
  end
  // Updated only on loop ticks, PI returns as soon as level drops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      p_q <= 1'b0;
    end else if (tick) begin
      p_q <= p_d;
    end
  end
  assign p_mode = p_q;
  off_never_p_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state_q == COND_OFF) && $past(state_q == COND_OFF) |-> !p_q)
    else $error("switch active while disabled");
  perr_pos_a: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(p_q) && state_q == COND_PERR && $past(state_q == COND_PERR) |-> $past(pos_mode))
    else $error("position error switch outside position control");
  hold_no_tick_a: assert property (@(posedge clk) disable iff (!arst_n)
    !$past(tick) |-> $stable(p_q))
    else $error("mode changed without loop tick");
endmodule

/* File: sgm_lag.sv */
// First-order lag stage: y += (x - y) * k / 2^16, k given per loop tick.
// k = 0 holds the output; pass-through comes only from bypass.
`timescale 1ns/1ps
module sgm_lag
  import sgm_pkg::*;
#(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Stream
  input wire logic tick,
  input wire logic bypass,
  input wire logic [15:0] k,
  input wire logic signed [W-1:0] x,
  output logic signed [W-1:0] y
);
  logic signed [W+17:0] acc_q;
  logic signed [W+17:0] diff;
  assign diff = (W+18)'(x) - (W+18)'(acc_q >>> 16);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_q <= '0;
    end else if (tick) begin
      if (bypass) begin
        acc_q <= (W+18)'(x) <<< 16;
      end else begin
        acc_q <= acc_q + (W+18)'(diff * $signed({1'b0, k}));
      end
    end
  end
  assign y = W'(acc_q >>> 16);
endmodule

/* File: sgm_top.sv */
// Servo gain scaling, feedforward, mode switch and torque filter chain.
// Assumes a Wishbone classic master on SYS_CLK and signed 16-bit loop quantities.
`timescale 1ns/1ps
module sgm_top
  import sgm_pkg::*;
#(
  parameter int LOOP_DIV = LOOP_CYC
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [5:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Loop quantities
  input wire logic POS_MODE,
  input wire logic signed [15:0] POS_REF_DELTA,
  input wire sgm_levels_type LEVELS,
  input wire logic signed [15:0] TORQUE_IN,
  input wire logic NOTCH1_OUT_VALID,
  input wire logic signed [15:0] NOTCH1_RET,
  input wire logic signed [15:0] NOTCH2_RET,
  // Results
  output logic [31:0] CUR_LOOP_GAIN,
  output logic SPD_DET_METHOD2,
  output logic signed [15:0] FF_OUT,
  output logic P_MODE,
  output logic signed [15:0] LAG_OUT,
  output logic NOTCH1_EN,
  output logic NOTCH2_EN,
  output logic signed [15:0] TORQUE_OUT,
  output logic LOOP_TICK
);
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [15:0] cur_gain_scale_q;
  logic [15:0] application_function_select_q;
  logic [15:0] feedforward_gain_q;
  logic [15:0] feedforward_filter_time_q;
  logic [15:0] switch_condition_select_q;
  logic [15:0] torque_switch_threshold_q;
  logic [15:0] speed_switch_threshold_q;
  logic [15:0] accel_switch_threshold_q;
  logic [15:0] position_error_switch_threshold_q;
  logic [15:0] notch_enable_select_q;
  logic [15:0] speed_loop_gain_q;
  logic spd_det_q;
  logic restart_seen_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic [15:0] wdat;
  logic wr;
  logic rd;
  logic [31:0] rdat_d;
  assign wdat = {WB_SEL_I[1] ? WB_DAT_I[15:8] : 8'h00, WB_SEL_I[0] ? WB_DAT_I[7:0] : 8'h00};
  assign wr = WB_CYC_I && WB_STB_I && WB_WE_I && !ack_q;
  assign rd = WB_CYC_I && WB_STB_I && !ack_q;
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                        input logic [3:0] sel);
    merge = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
  endfunction
  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                        input logic [15:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction
  // ---------------------------------------------------------------
  // Register writes, current gain level, feedforward and torque/speed/accel threshold values clamped into documented ranges
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cur_gain_scale_q <= CUR_GAIN_RST;
      application_function_select_q <= ZERO16;
      feedforward_gain_q <= ZERO16;
      feedforward_filter_time_q <= ZERO16;
      switch_condition_select_q <= ZERO16;
      torque_switch_threshold_q <= TRQ_THR_RST;
      speed_switch_threshold_q <= ZERO16;
      accel_switch_threshold_q <= ACC_THR_RST;
      position_error_switch_threshold_q <= ZERO16;
      notch_enable_select_q <= ZERO16;
      speed_loop_gain_q <= SPD_GAIN_RST;
    end else if (wr) begin
      case (WB_ADR_I)
        REG_CUR_GAIN: cur_gain_scale_q <= clamp(merge(cur_gain_scale_q, wdat, WB_SEL_I),
                                               CUR_GAIN_MIN, CUR_GAIN_MAX);
        REG_APP_SEL: application_function_select_q <=
                       merge(application_function_select_q, wdat, WB_SEL_I);
        REG_FF_GAIN: feedforward_gain_q <= clamp(merge(feedforward_gain_q, wdat, WB_SEL_I),
                                                 ZERO16, FF_GAIN_MAX);
        REG_FF_TIME: feedforward_filter_time_q <= clamp(merge(feedforward_filter_time_q,
                                                  wdat, WB_SEL_I), ZERO16, FF_TIME_MAX);
        REG_SW_COND: switch_condition_select_q <= merge(switch_condition_select_q, wdat,
                                                        WB_SEL_I);
        REG_TRQ_THR: torque_switch_threshold_q <= clamp(merge(torque_switch_threshold_q,
                                                  wdat, WB_SEL_I), ZERO16, TRQ_THR_MAX);
        REG_SPD_THR: speed_switch_threshold_q <= clamp(merge(speed_switch_threshold_q,
                                                 wdat, WB_SEL_I), ZERO16, SPD_THR_MAX);
        REG_ACC_THR: accel_switch_threshold_q <= clamp(merge(accel_switch_threshold_q,
                                                 wdat, WB_SEL_I), ZERO16, ACC_THR_MAX);
        REG_PERR_THR: position_error_switch_threshold_q <=
                        merge(position_error_switch_threshold_q, wdat, WB_SEL_I);
        REG_NOTCH_EN: notch_enable_select_q <= merge(notch_enable_select_q, wdat,
                                                     WB_SEL_I);
        REG_SPD_GAIN: speed_loop_gain_q <= merge(speed_loop_gain_q, wdat, WB_SEL_I);
        default: ;
      endcase
    end
  end
  // Speed detection latched once after reset release from the reset value 0, so later writes never reach SPD_DET_METHOD2
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      spd_det_q <= 1'b0;
      restart_seen_q <= 1'b0;
    end else if (!restart_seen_q) begin
      spd_det_q <= application_function_select_q[SPD_DET_BIT];
      restart_seen_q <= 1'b1;
    end
  end
  assign SPD_DET_METHOD2 = spd_det_q;
  // ---------------------------------------------------------------
  // Bus answer, registered: ack one cycle after the request
  // ---------------------------------------------------------------
  always_comb begin
    case (WB_ADR_I)
      REG_CUR_GAIN: rdat_d = {16'h0000, cur_gain_scale_q};
      REG_APP_SEL: rdat_d = {16'h0000, application_function_select_q};
      REG_FF_GAIN: rdat_d = {16'h0000, feedforward_gain_q};
      REG_FF_TIME: rdat_d = {16'h0000, feedforward_filter_time_q};
      REG_SW_COND: rdat_d = {16'h0000, switch_condition_select_q};
      REG_TRQ_THR: rdat_d = {16'h0000, torque_switch_threshold_q};
      REG_SPD_THR: rdat_d = {16'h0000, speed_switch_threshold_q};
      REG_ACC_THR: rdat_d = {16'h0000, accel_switch_threshold_q};
      REG_PERR_THR: rdat_d = {16'h0000, position_error_switch_threshold_q};
      REG_NOTCH_EN: rdat_d = {16'h0000, notch_enable_select_q};
      REG_SPD_GAIN: rdat_d = {16'h0000, speed_loop_gain_q};
      REG_STATUS: rdat_d = {29'h00000000, spd_det_q, P_MODE, POS_MODE};
      default: rdat_d = 32'h00000000;
    endcase
  end
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= rd;
      if (rd) begin
        rdat_q <= rdat_d;
      end
    end
  end
  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdat_q;
  // ---------------------------------------------------------------
  // Speed loop tick divider
  // ---------------------------------------------------------------
  logic [15:0] div_q;
  logic tick_q;
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      div_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (div_q == 16'(LOOP_DIV - 1));
      div_q <= (div_q == 16'(LOOP_DIV - 1)) ? 16'h0000 : div_q + 16'h0001;
    end
  end
  assign LOOP_TICK = tick_q;
  // ---------------------------------------------------------------
  // Current loop gain, scaled by gain level; 2000 percent leaves it at 20x
  // ---------------------------------------------------------------
  logic [31:0] cur_gain_q;
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cur_gain_q <= 32'h00000000;
    end else begin
      cur_gain_q <= (32'(speed_loop_gain_q) * 32'(cur_gain_scale_q)) / 32'(PCT_DIV);
    end
  end
  assign CUR_LOOP_GAIN = cur_gain_q;
  // ---------------------------------------------------------------
  // Feedforward: gain then lag filter, only in position control
  // ---------------------------------------------------------------
  logic signed [15:0] ff_raw;
  logic signed [15:0] ff_filt;
  logic [15:0] ff_k;
  logic [31:0] ff_k_full;
  assign ff_raw = POS_MODE ? 16'((32'(POS_REF_DELTA) * $signed({1'b0, feedforward_gain_q}))
                                 / $signed({1'b0, PCT_DIV})) : 16'sh0000;
  // Step factor k = loop period / time constant, in 1/65536 units
  assign ff_k_full = (feedforward_filter_time_q == ZERO16) ? 32'h00010000 :
                     ((32'(LOOP_NS) << 16) / (32'(feedforward_filter_time_q) * 32'(FF_STEP_NS)));
  assign ff_k = (ff_k_full > 32'h0000ffff) ? 16'hffff : ff_k_full[15:0];
  sgm_lag #(.W(16)) u_ff_lag (
    .clk(SYS_CLK),
    .arst_n(ARST_N),
    .tick(tick_q),
    .bypass(feedforward_filter_time_q == ZERO16),
    .k(ff_k),
    .x(ff_raw),
    .y(ff_filt)
  );
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      FF_OUT <= 16'sh0000;
    end else begin
      FF_OUT <= POS_MODE ? ff_filt : 16'sh0000;
    end
  end
  // ---------------------------------------------------------------
  // Mode switch
  // ---------------------------------------------------------------
  sgm_switch_cfg_type sw_cfg;
  assign sw_cfg = '{trq_thr: torque_switch_threshold_q, spd_thr: speed_switch_threshold_q,
                    acc_thr: accel_switch_threshold_q, perr_thr: position_error_switch_threshold_q,
                    cond: switch_condition_select_q[COND_LSB +: 4]};
  sgm_mode_switch u_sw (
    .clk(SYS_CLK),
    .arst_n(ARST_N),
    .tick(tick_q),
    .pos_mode(POS_MODE),
    .cfg(sw_cfg),
    .lev(LEVELS),
    .p_mode(P_MODE)
  );
  // ---------------------------------------------------------------
  // Torque chain: lag output feeds external notches, each bypassable
  // ---------------------------------------------------------------
  logic signed [15:0] lag_y;
  sgm_lag #(.W(16)) u_trq_lag (
    .clk(SYS_CLK),
    .arst_n(ARST_N),
    .tick(tick_q),
    .bypass(1'b0),
    .k(16'hffff),
    .x(TORQUE_IN),
    .y(lag_y)
  );
  assign NOTCH1_EN = notch_enable_select_q[NOTCH1_BIT];
  assign NOTCH2_EN = notch_enable_select_q[NOTCH2_BIT];
  logic signed [15:0] n1_q;
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      LAG_OUT <= 16'sh0000;
      n1_q <= 16'sh0000;
      TORQUE_OUT <= 16'sh0000;
    end else begin
      LAG_OUT <= lag_y;
      if (NOTCH1_OUT_VALID || !NOTCH1_EN) begin
        n1_q <= NOTCH1_EN ? NOTCH1_RET : LAG_OUT;
      end
      TORQUE_OUT <= NOTCH2_EN ? NOTCH2_RET : n1_q;
    end
  end
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence bus_req_s;
    WB_CYC_I && WB_STB_I && !ack_q;
  endsequence
  bus_ack_one_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    bus_req_s |=> WB_ACK_O ##1 !WB_ACK_O)
    else $error("ack not a single cycle after request");
  cur_gain_range_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    cur_gain_scale_q >= CUR_GAIN_MIN && cur_gain_scale_q <= CUR_GAIN_MAX)
    else $error("current gain level out of range");
  ff_gain_range_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    feedforward_gain_q <= FF_GAIN_MAX)
    else $error("feedforward gain out of range");
  ff_off_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    !$past(POS_MODE) |-> FF_OUT == 16'sh0000)
    else $error("feedforward outside position control");
  spd_det_hold_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    restart_seen_q && $past(restart_seen_q) |-> $stable(spd_det_q))
    else $error("speed detection changed without restart");
  notch2_bypass_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
    !$past(NOTCH2_EN) |-> TORQUE_OUT == $past(n1_q))
    else $error("second notch not bypassed");
endmodule

/* File: sgm_motor.sv */
// Motor side model: sampled feedback levels and external notch stage results.
// Assumes the bench commands the levels; notch stages return their input.
`timescale 1ns/1ps
module sgm_motor
  import sgm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Commanded feedback and torque path
  input wire sgm_levels_type cmd,
  input wire logic signed [15:0] lag_in,
  // Back to the block
  output sgm_levels_type lev,
  output logic signed [15:0] n1_ret,
  output logic signed [15:0] n2_ret,
  output logic n1_valid
);
  // Feedback moves only on the clock, like a sampled encoder
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lev <= '0;
      n1_ret <= 16'sh0000;
      n2_ret <= 16'sh0000;
      n1_valid <= 1'b0;
    end else begin
      lev <= cmd;
      // Notch far from its frequency: unity gain, a limitation of this model
      n1_ret <= lag_in;
      n2_ret <= lag_in;
      n1_valid <= 1'b1;
    end
  end
endmodule

/* File: sgm_top_tb.sv */
// Bench for the gain and mode switch block: registers, P/PI switching, notch enables.
// Assumes a loop divider of 4, so a speed loop tick comes every four clocks.
`timescale 1ns/1ps
module sgm_top_tb import sgm_pkg::*; ;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, pos_mode = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [3:0] sel = 4'h3;
  logic [31:0] wdat = 32'h0, rdat, cur_gain, q;
  logic ack, spd_det2, p_mode, n1_en, n2_en, loop_tick, n1_valid;
  logic signed [15:0] pos_delta = 16'sh0000, torque_in = 16'sh0000;
  logic signed [15:0] ff_out, lag_out, torque_out, n1_ret, n2_ret;
  sgm_levels_type cmd = '0, lev;
  int n_mismatch = 0, cmp_count = 0;
  typedef struct packed {
    logic [3:0] cond;
    logic [5:0] adr;
    logic [15:0] thr;
    logic [63:0] lev;
    logic pos;
    logic exp;
  } sgm_row_type;
  sgm_row_type rows [8] = '{
    '{4'h0, REG_TRQ_THR, 16'h00c8, 64'h00c9_0000_0000_0000, 1'b0, 1'b1},
    '{4'h0, REG_TRQ_THR, 16'h00c8, 64'hff37_0000_0000_0000, 1'b0, 1'b1},
    '{4'h0, REG_TRQ_THR, 16'h00c8, 64'h00c8_0000_0000_0000, 1'b0, 1'b0},
    '{4'h1, REG_SPD_THR, 16'h0064, 64'h0000_0065_0000_0000, 1'b0, 1'b1},
    '{4'h2, REG_ACC_THR, 16'h0064, 64'h0000_0000_ff9b_0000, 1'b0, 1'b1},
    '{4'h3, REG_PERR_THR, 16'h0064, 64'h0000_0000_0000_0065, 1'b1, 1'b1},
    '{4'h3, REG_PERR_THR, 16'h0064, 64'h0000_0000_0000_0065, 1'b0, 1'b0},
    '{4'h4, REG_TRQ_THR, 16'h0000, 64'h0320_0320_0320_0320, 1'b1, 1'b0}};
  logic [5:0] ra [6] = '{REG_CUR_GAIN, REG_FF_GAIN, REG_FF_TIME, REG_TRQ_THR,
    REG_SPD_THR, REG_ACC_THR};
  logic [15:0] rv [6] = '{CUR_GAIN_RST, ZERO16, ZERO16, TRQ_THR_RST, ZERO16, ACC_THR_RST};

  always #2.5 clk = ~clk;

  sgm_top #(.LOOP_DIV(4)) i_dut (.SYS_CLK(clk), .ARST_N(arst_n), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .POS_MODE(pos_mode), .POS_REF_DELTA(pos_delta),
    .LEVELS(lev), .TORQUE_IN(torque_in), .NOTCH1_OUT_VALID(n1_valid),
    .NOTCH1_RET(n1_ret), .NOTCH2_RET(n2_ret), .CUR_LOOP_GAIN(cur_gain),
    .SPD_DET_METHOD2(spd_det2), .FF_OUT(ff_out), .P_MODE(p_mode), .LAG_OUT(lag_out),
    .NOTCH1_EN(n1_en), .NOTCH2_EN(n2_en), .TORQUE_OUT(torque_out),
    .LOOP_TICK(loop_tick));
  sgm_motor i_motor (.clk(clk), .arst_n(arst_n), .cmd(cmd), .lag_in(lag_out),
    .lev(lev), .n1_ret(n1_ret), .n2_ret(n2_ret), .n1_valid(n1_valid));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Held until ack is sampled; no answer latency is assumed
  task automatic wb(input logic w, input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'h0000, d};
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rdc(input logic [5:0] a, input logic [15:0] exp);
    wb(1'b0, a, 16'h0000);
    chk(q, {16'h0000, exp});
  endtask
  // Ticks are sampled on the edge, outputs looked at once settled
  task automatic loops(input int k);
    repeat (k) begin
      @(posedge clk);
      while (loop_tick !== 1'b1)
        @(posedge clk);
    end
    @(posedge clk);
    #1;
  endtask

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    #200000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    foreach (ra[i])
      rdc(ra[i], rv[i]);
    loops(1);
    chk(cur_gain, 32'd800);
    foreach (rows[i]) begin
      wb(1'b1, REG_SW_COND, {12'h000, rows[i].cond});
      wb(1'b1, rows[i].adr, rows[i].thr);
      cmd <= rows[i].lev;
      pos_mode <= rows[i].pos;
      loops(3);
      chk({31'h0, p_mode}, {31'h0, rows[i].exp});
    end
    // Out-of-range settings are clamped rather than refused
    wb(1'b1, REG_CUR_GAIN, 16'h0032);
    rdc(REG_CUR_GAIN, 16'h0064);
    loops(1);
    chk(cur_gain, 32'd40);
    wb(1'b1, REG_SPD_GAIN, 16'h0064);
    wb(1'b1, REG_CUR_GAIN, 16'h0bb8);
    rdc(REG_CUR_GAIN, 16'h07d0);
    loops(1);
    chk(cur_gain, 32'd2000);
    wb(1'b1, REG_FF_GAIN, 16'h00c8);
    rdc(REG_FF_GAIN, 16'h0064);
    wb(1'b1, 6'h30, 16'h1234);
    rdc(6'h30, 16'h0000);
    // Speed detection change must wait for a restart
    wb(1'b1, REG_APP_SEL, 16'h0100);
    rdc(REG_APP_SEL, 16'h0100);
    loops(2);
    chk({31'h0, spd_det2}, 32'h0);
    pos_mode <= 1'b1;
    pos_delta <= 16'sh0032;
    torque_in <= 16'sh0123;
    loops(3);
    chk({16'h0000, ff_out}, 32'h0032);
    chk({16'h0000, lag_out}, 32'h0123);
    chk({16'h0000, torque_out}, 32'h0123);
    chk({30'h0, n1_en, n2_en}, 32'h0);
    wb(1'b1, REG_NOTCH_EN, 16'h0001);
    loops(1);
    chk({30'h0, n1_en, n2_en}, 32'h2);
    wb(1'b1, REG_NOTCH_EN, 16'h0100);
    loops(3);
    chk({30'h0, n1_en, n2_en}, 32'h1);
    chk({16'h0000, torque_out}, 32'h0123);
    wb(1'b1, REG_FF_GAIN, 16'h0000);
    loops(3);
    chk({16'h0000, ff_out}, 32'h0);
    // Second reset in mid-run restores defaults
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    rdc(REG_CUR_GAIN, CUR_GAIN_RST);
    end_sim();
  end
endmodule
